// file: verilog/packet_protocol_config_regs.sv
// Packet handler and protocol engine configuration registers on an AHB-Lite slave port.
// Assumes the sole slave on the bus, word transfers only, and datapath inputs on clk.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module packet_protocol_config_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [packet_cfg_pkg::HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Datapath events and flags
   input wire logic seqReloadRequest,
   input wire logic seqAdvance,
   input wire logic txAlmostEmpty,
   input wire logic txAlmostFull,
   input wire logic rxAlmostEmpty,
   input wire logic rxAlmostFull,
   input wire logic [2:0] syncQualityIndicator,
   // CRC and coding controls
   output logic crcEnable,
   output logic [5:0] crcWidth,
   output logic [packet_cfg_pkg::CRC_POLY_W-1:0] crcPolynomial,
   output logic whiteningEnable,
   output logic [1:0] transmitOriginSelect,
   output logic txUseSecondarySync,
   output logic rxDualSyncDetect,
   output logic errorCorrectionEnable,
   // Packet framing
   output logic [15:0] packetLength,
   output logic [31:0] syncWord,
   output logic [2:0] syncQualityThreshold,
   output logic [3:0] preambleQualityThreshold,
   output logic syncQualityCheckEnable,
   output logic syncQualityPass,
   output logic [7:0] postambleLengthField,
   // Protocol controls
   output logic csTimeoutStop,
   output logic syncQualityTimeoutStop,
   output logic preambleQualityTimeoutStop,
   output logic [1:0] txSequenceNumber,
   output logic gpioAlmostEmpty,
   output logic gpioAlmostFull,
   output logic [1:0] wakeupTimerMultiplier,
   output logic dutyCycleEnable,
   output logic wakeupReloadOnSyncEnable,
   output logic piggybackEnable,
   output logic sniffTimerEnable,
   output logic backoffSeedReload,
   output logic listenBeforeTalkEnable,
   output logic persistentAccessEnable,
   output logic automaticFilterEnable
);
   import packet_cfg_pkg::*;

   // ==========================================================================
   // State
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic wrPending;
      logic wrHit;
      logic wrCmd;
      logic [3:0] wrSlot;
      logic [1:0] seqCount;
      logic readyOut;
      logic [31:0] rdata;
      logic crcEn;
      logic [5:0] crcW;
      logic [CRC_POLY_W-1:0] crcPoly;
      logic sqPass;
      logic gpioEmpty;
      logic gpioFull;
      logic seedPulse;
   } state_s;

   state_s cur;
   state_s next_cur;

   // ==========================================================================
   // Decode
   // Maps a word index to a register slot; unmapped indices return hit low.
   function automatic logic [4:0] decodeSlot(input logic [7:0] idx);
      logic [4:0] res;
      logic [7:0] off;
      res = 5'h00;
      off = idx - IDX_PKT_CTRL;
      if (idx >= IDX_PKT_CTRL && idx <= IDX_LAST) begin
         res = {1'b1, off[3:0]};
      end
      return res;
   endfunction : decodeSlot

   function automatic logic [7:0] regByte(input logic [NUM_REGS-1:0][7:0] r,
                                          input logic [7:0] idx);
      logic [7:0] off;
      off = idx - IDX_PKT_CTRL;
      return r[off[3:0]];
   endfunction : regByte

   // ==========================================================================
   // Next state
   always_comb begin
      logic [4:0] slot;
      logic [7:0] idx;
      logic [7:0] pc;
      logic [7:0] qi;
      logic [7:0] pt;
      logic reload;
      slot = 5'h00;
      idx = 8'h00;
      pc = 8'h00;
      qi = 8'h00;
      pt = 8'h00;
      reload = 1'b0;
      next_cur = cur;
      next_cur.readyOut = 1'b1;
      next_cur.seedPulse = 1'b0;

      // Data phase of a write lands the low byte; the bus stays zero-wait.
      if (cur.wrPending) begin
         if (cur.wrHit) begin
            next_cur.regs[cur.wrSlot] = hwdata[7:0];
         end
         if (cur.wrCmd && hwdata[CMD_SEQ_RELOAD_BIT]) begin
            reload = 1'b1;
         end
         if (cur.wrHit && cur.wrSlot == 4'(IDX_PROTO_ACCESS - IDX_PKT_CTRL)
             && hwdata[SEED_BIT]) begin
            next_cur.seedPulse = 1'b1;
         end
      end

      // A reload request beats a same-cycle advance so the loaded value is seen.
      pt = regByte(next_cur.regs, IDX_PROTO_TIMEOUT);
      if (reload || seqReloadRequest) begin
         next_cur.seqCount = pt[SEQ_HI:SEQ_LO];
      end else if (seqAdvance) begin
         next_cur.seqCount = cur.seqCount + 2'h1;
      end

      // Address phase.
      next_cur.wrPending = 1'b0;
      next_cur.wrHit = 1'b0;
      next_cur.wrCmd = 1'b0;
      if (hsel && htrans == HTRANS_NONSEQ && hready) begin
         idx = haddr[HADDR_W-1:2];
         slot = decodeSlot(idx);
         if (hwrite) begin
            next_cur.wrPending = 1'b1;
            next_cur.wrHit = slot[4];
            next_cur.wrSlot = slot[3:0];
            next_cur.wrCmd = (idx == IDX_SEQ_CMD);
         end else if (slot[4]) begin
            // Reads see a write that completes in this same cycle.
            next_cur.rdata = {24'h000000, next_cur.regs[slot[3:0]]};
         end else if (idx == IDX_SEQ_CMD) begin
            next_cur.rdata = {30'h00000000, next_cur.seqCount};
         end else begin
            next_cur.rdata = 32'h00000000;
         end
      end

      // Derived controls follow the registers in the same edge.
      pc = regByte(next_cur.regs, IDX_PKT_CTRL);
      next_cur.crcEn = 1'b1;
      unique case (pc[CRC_HI:CRC_LO])
         CRC_POLY8: begin
            next_cur.crcW = CRC_W_8;
            next_cur.crcPoly = POLY_8;
         end
         CRC_POLY16A: begin
            next_cur.crcW = CRC_W_16;
            next_cur.crcPoly = POLY_16A;
         end
         CRC_POLY16B: begin
            next_cur.crcW = CRC_W_16;
            next_cur.crcPoly = POLY_16B;
         end
         CRC_POLY24: begin
            next_cur.crcW = CRC_W_24;
            next_cur.crcPoly = POLY_24;
         end
         CRC_POLY32: begin
            next_cur.crcW = CRC_W_32;
            next_cur.crcPoly = POLY_32;
         end
         default: begin
            // Codes 6 and 7 are undefined and treated like no CRC field.
            next_cur.crcEn = 1'b0;
            next_cur.crcW = 6'h00;
            next_cur.crcPoly = '0;
         end
      endcase

      qi = regByte(next_cur.regs, IDX_QUALITY);
      next_cur.sqPass = !qi[SQ_EN_BIT] || (syncQualityIndicator >= qi[SQT_HI:SQT_LO]);

      if (pt[FIFO_ROUTE_BIT]) begin
         next_cur.gpioEmpty = txAlmostEmpty;
         next_cur.gpioFull = txAlmostFull;
      end else begin
         next_cur.gpioEmpty = rxAlmostEmpty;
         next_cur.gpioFull = rxAlmostFull;
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur.regs <= REG_RESET;
         cur.wrPending <= 1'b0;
         cur.wrHit <= 1'b0;
         cur.wrCmd <= 1'b0;
         cur.wrSlot <= 4'h0;
         cur.seqCount <= 2'h0;
         cur.readyOut <= 1'b1;
         cur.rdata <= 32'h00000000;
         cur.crcEn <= 1'b1;
         cur.crcW <= CRC_W_8;
         cur.crcPoly <= POLY_8;
         cur.sqPass <= 1'b1;
         cur.gpioEmpty <= 1'b0;
         cur.gpioFull <= 1'b0;
         cur.seedPulse <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================================
   // Outputs, all but hresp taken straight from the state register; hresp is tied low.
   assign hreadyout = cur.readyOut;
   assign hresp = 1'b0;
   assign hrdata = cur.rdata;

   assign crcEnable = cur.crcEn;
   assign crcWidth = cur.crcW;
   assign crcPolynomial = cur.crcPoly;
   assign whiteningEnable = cur.regs[0][WHITEN_BIT];
   assign transmitOriginSelect = cur.regs[0][TXSRC_HI:TXSRC_LO];
   // One bit serves both directions; the datapath picks its meaning per mode.
   assign txUseSecondarySync = cur.regs[0][SYNC_SEL_BIT];
   assign rxDualSyncDetect = cur.regs[0][SYNC_SEL_BIT];
   assign errorCorrectionEnable = cur.regs[0][FEC_BIT];

   assign packetLength = {cur.regs[1], cur.regs[2]};
   assign syncWord = {cur.regs[3], cur.regs[4], cur.regs[5], cur.regs[6]};
   assign syncQualityThreshold = cur.regs[7][SQT_HI:SQT_LO];
   assign preambleQualityThreshold = cur.regs[7][PQT_HI:PQT_LO];
   assign syncQualityCheckEnable = cur.regs[7][SQ_EN_BIT];
   assign syncQualityPass = cur.sqPass;
   assign postambleLengthField = cur.regs[8];

   assign csTimeoutStop = cur.regs[9][CS_MASK_BIT];
   assign syncQualityTimeoutStop = cur.regs[9][SQ_MASK_BIT];
   assign preambleQualityTimeoutStop = cur.regs[9][PQ_MASK_BIT];
   assign txSequenceNumber = cur.seqCount;
   assign gpioAlmostEmpty = cur.gpioEmpty;
   assign gpioAlmostFull = cur.gpioFull;
   assign wakeupTimerMultiplier = cur.regs[9][MULT_HI:MULT_LO];

   assign dutyCycleEnable = cur.regs[10][DUTY_BIT];
   assign wakeupReloadOnSyncEnable = cur.regs[10][RELOAD_SYNC_BIT];
   assign piggybackEnable = cur.regs[10][PIGGY_BIT];
   assign sniffTimerEnable = cur.regs[10][SNIFF_BIT];
   // A pulse per write with the bit set lets the generator reload even if it stays set.
   assign backoffSeedReload = cur.seedPulse;
   assign listenBeforeTalkEnable = cur.regs[10][LBT_BIT];
   assign persistentAccessEnable = cur.regs[10][PERSIST_BIT];
   assign automaticFilterEnable = cur.regs[10][FILTER_BIT];
endmodule : packet_protocol_config_regs

// file: include/packet_cfg_pkg.sv
// Constants for the packet and protocol configuration register slice.
// Assumes a single 20 MHz clock and an AHB-Lite master that issues single word transfers.
//
// Overview of operation
// - CRC code 5 selects 32-bit polynomial.
// - CRC field bits 7:5; codes 0-5 defined.
// - Bit 4 enables packet whitening.
// - Bits 3:2 choose transmit data origin.
// - Sync-select bit chooses secondary transmit sync word.
// - Sync-select bit enables dual sync receive search.
// - Bit 0 enables error correction and decoding.
// - Sixteen-bit packet length, reset 0x0014.
// - Quality thresholds and sync quality check enable.
// - Eight-bit postamble length register.
// - Three masks allow timeout disabling sources.
// - Sequence reset loads counter from reload field.
// - Bit 2 routes transmit or receive FIFO flags.
// - Bits 1:0 select wake-up timer multiplier.
// - Bit 7 enables low duty cycle mode.
// - Bit 6 reloads wake-up timer on sync.
// - Bit 5 enables acknowledgment piggybacking.
// - Bit 4 enables receive sniff timer.
// - Bit 3 reloads back-off generator seed.
// - Bit 2 enables listen-before-talk access.
// - Bit 1 selects persistent access, no back-off.
// - Bit 0 enables automatic packet filtering.
package packet_cfg_pkg;
   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam int NUM_REGS = 11;
   localparam logic [7:0] IDX_PKT_CTRL = 8'h30;
   localparam logic [7:0] IDX_LEN_HIGH = 8'h31;
   localparam logic [7:0] IDX_LEN_LOW = 8'h32;
   localparam logic [7:0] IDX_SYNC_BYTE_THREE = 8'h33;
   localparam logic [7:0] IDX_SYNC_BYTE_TWO = 8'h34;
   localparam logic [7:0] IDX_SYNC_BYTE_ONE = 8'h35;
   localparam logic [7:0] IDX_SYNC_BYTE_ZERO = 8'h36;
   localparam logic [7:0] IDX_QUALITY = 8'h37;
   localparam logic [7:0] IDX_POSTAMBLE = 8'h38;
   localparam logic [7:0] IDX_PROTO_TIMEOUT = 8'h39;
   localparam logic [7:0] IDX_PROTO_ACCESS = 8'h3A;
   localparam logic [7:0] IDX_SEQ_CMD = 8'h60;
   localparam logic [7:0] IDX_LAST = IDX_PROTO_ACCESS;
   // ==========================================================================
   // Reset values, in index order from the protocol access register down to the packet control register.
   localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
      8'h00, 8'h40, 8'h00, 8'h01, 8'h88, 8'h88, 8'h88, 8'h88, 8'h14, 8'h00, 8'h2C};
   // ==========================================================================
   // Field positions.
   localparam int CRC_HI = 7;
   localparam int CRC_LO = 5;
   localparam int WHITEN_BIT = 4;
   localparam int TXSRC_HI = 3;
   localparam int TXSRC_LO = 2;
   localparam int SYNC_SEL_BIT = 1;
   localparam int FEC_BIT = 0;
   localparam int SQT_HI = 7;
   localparam int SQT_LO = 5;
   localparam int PQT_HI = 4;
   localparam int PQT_LO = 1;
   localparam int SQ_EN_BIT = 0;
   localparam int CS_MASK_BIT = 7;
   localparam int SQ_MASK_BIT = 6;
   localparam int PQ_MASK_BIT = 5;
   localparam int SEQ_HI = 4;
   localparam int SEQ_LO = 3;
   localparam int FIFO_ROUTE_BIT = 2;
   localparam int MULT_HI = 1;
   localparam int MULT_LO = 0;
   localparam int DUTY_BIT = 7;
   localparam int RELOAD_SYNC_BIT = 6;
   localparam int PIGGY_BIT = 5;
   localparam int SNIFF_BIT = 4;
   localparam int SEED_BIT = 3;
   localparam int LBT_BIT = 2;
   localparam int PERSIST_BIT = 1;
   localparam int FILTER_BIT = 0;
   localparam int CMD_SEQ_RELOAD_BIT = 0;
   // ==========================================================================
   // CRC selection.
   typedef enum logic [2:0] {
      CRC_NONE, CRC_POLY8, CRC_POLY16A, CRC_POLY16B, CRC_POLY24, CRC_POLY32
   } crc_mode_e;
   localparam int CRC_POLY_W = 36;
   localparam logic [CRC_POLY_W-1:0] POLY_8 = 36'h000000007;
   localparam logic [CRC_POLY_W-1:0] POLY_16A = 36'h000008005;
   localparam logic [CRC_POLY_W-1:0] POLY_16B = 36'h000001021;
   localparam logic [CRC_POLY_W-1:0] POLY_24 = 36'h000864CBF;
   localparam logic [CRC_POLY_W-1:0] POLY_32 = 36'h04C011BB7;
   localparam logic [5:0] CRC_W_8 = 6'h08;
   localparam logic [5:0] CRC_W_16 = 6'h10;
   localparam logic [5:0] CRC_W_24 = 6'h18;
   localparam logic [5:0] CRC_W_32 = 6'h20;
   // Transmit data origin codes.
   localparam logic [1:0] TXSRC_NORMAL = 2'h0;
   localparam logic [1:0] TXSRC_FIFO = 2'h1;
   localparam logic [1:0] TXSRC_GPIO = 2'h2;
   localparam logic [1:0] TXSRC_PN9 = 2'h3;
   // AHB constants.
   localparam int HADDR_W = 10;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : packet_cfg_pkg

// file: verification/packet_cfg_props.sv
// Concurrent checks for the packet and protocol configuration registers.
// Assumes it is bound to the register block and sees only that block's ports.
`timescale 1ns/1ps
module packet_cfg_props (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [packet_cfg_pkg::HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // Datapath inputs
   input wire logic seqReloadRequest,
   input wire logic txAlmostEmpty,
   input wire logic rxAlmostEmpty,
   input wire logic [2:0] syncQualityIndicator,
   // Watched outputs
   input wire logic [5:0] crcWidth,
   input wire logic [packet_cfg_pkg::CRC_POLY_W-1:0] crcPolynomial,
   input wire logic whiteningEnable,
   input wire logic [1:0] transmitOriginSelect,
   input wire logic txUseSecondarySync,
   input wire logic rxDualSyncDetect,
   input wire logic errorCorrectionEnable,
   input wire logic [15:0] packetLength,
   input wire logic [2:0] syncQualityThreshold,
   input wire logic syncQualityCheckEnable,
   input wire logic syncQualityPass,
   input wire logic [1:0] txSequenceNumber,
   input wire logic gpioAlmostEmpty,
   input wire logic dutyCycleEnable,
   input wire logic automaticFilterEnable,
   input wire logic backoffSeedReload
);
   import packet_cfg_pkg::*;
   // ==========================================================================
   // Helper state: the write data phase and a mirror of the timeout register.
   logic wrPend;
   logic [7:0] wrIdx;
   logic [7:0] protoT;
   logic seedHit;
   function automatic logic wr(input logic [7:0] i);
      return wrPend && wrIdx == i;
   endfunction : wr
   assign seedHit = wr(IDX_PROTO_ACCESS) && hwdata[SEED_BIT];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend <= 1'b0;
         wrIdx <= 8'h00;
         protoT <= 8'h40;
      end else begin
         wrPend <= hsel && htrans == HTRANS_NONSEQ && hready && hwrite;
         wrIdx <= haddr[9:2];
         if (wr(IDX_PROTO_TIMEOUT)) begin
            protoT <= hwdata[7:0];
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================================
   // Properties. Checks right after reset are guarded by the past reset level.
   property p_crc32;
      wr(IDX_PKT_CTRL) && hwdata[7:5] == 3'h5 |=> crcPolynomial == POLY_32 && crcWidth == 6'h20;
   endproperty
   a_crc32: assert property (p_crc32) else $error("crc code 5 result wrong");
   property p_pktbits;
      wr(IDX_PKT_CTRL) |=> {whiteningEnable, transmitOriginSelect} == $past(hwdata[4:2])
         && errorCorrectionEnable == $past(hwdata[0]);
   endproperty
   a_pktbits: assert property (p_pktbits) else $error("control bits wrong");
   property p_syncsel;
      wr(IDX_PKT_CTRL) |=> txUseSecondarySync == $past(hwdata[1]) && rxDualSyncDetect == $past(hwdata[1]);
   endproperty
   a_syncsel: assert property (p_syncsel) else $error("sync select wrong");
   property p_len;
      wr(IDX_LEN_LOW) |=> packetLength[7:0] == $past(hwdata[7:0]) && $stable(packetLength[15:8]);
   endproperty
   a_len: assert property (p_len) else $error("length low byte wrong");
   property p_sq;
      $past(rst_n) |-> syncQualityPass == (!syncQualityCheckEnable
         || $past(syncQualityIndicator) >= syncQualityThreshold);
   endproperty
   a_sq: assert property (p_sq) else $error("sync quality pass wrong");
   property p_seq;
      seqReloadRequest |=> txSequenceNumber == protoT[4:3];
   endproperty
   a_seq: assert property (p_seq) else $error("sequence reload wrong");
   property p_gpio;
      $past(rst_n) |-> gpioAlmostEmpty == (protoT[2] ? $past(txAlmostEmpty)
         : $past(rxAlmostEmpty));
   endproperty
   a_gpio: assert property (p_gpio) else $error("fifo flag routing wrong");
   property p_seed;
      $past(rst_n) |-> backoffSeedReload == $past(seedHit);
   endproperty
   a_seed: assert property (p_seed) else $error("seed reload pulse wrong");
   property p_access;
      wr(IDX_PROTO_ACCESS) |=> dutyCycleEnable == $past(hwdata[7])
         && automaticFilterEnable == $past(hwdata[0]);
   endproperty
   a_access: assert property (p_access) else $error("access bits wrong");
   c_crc32: cover property (wr(IDX_PKT_CTRL) && hwdata[7:5] == 3'h5);
   c_seed: cover property (backoffSeedReload);
   c_race: cover property (seqReloadRequest && txSequenceNumber == 2'h3);
endmodule : packet_cfg_props

bind packet_protocol_config_regs packet_cfg_props u_props (.*);

// file: verification/tb.sv
// Self-checking bench for the packet and protocol configuration registers.
// Assumes the block is the only AHB-Lite slave, so hready is fed back from hreadyout.
`timescale 1ns/1ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb;
   import packet_cfg_pkg::*;
   typedef struct {logic [7:0] v; logic [5:0] w; logic [35:0] p;} row_s;
   // ==========================================================================
   // Signals
   logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [HADDR_W-1:0] haddr;
   logic [1:0] htrans, transmitOriginSelect, txSequenceNumber, wakeupTimerMultiplier;
   logic [2:0] hsize, syncQualityIndicator, syncQualityThreshold;
   logic [31:0] hwdata, hrdata, syncWord, rd;
   logic seqReloadRequest, seqAdvance, txAlmostEmpty, txAlmostFull, rxAlmostEmpty, rxAlmostFull;
   logic crcEnable, whiteningEnable, txUseSecondarySync, rxDualSyncDetect, errorCorrectionEnable;
   logic [5:0] crcWidth;
   logic [CRC_POLY_W-1:0] crcPolynomial;
   logic [15:0] packetLength;
   logic [3:0] preambleQualityThreshold;
   logic [7:0] postambleLengthField;
   logic syncQualityCheckEnable, syncQualityPass, csTimeoutStop, syncQualityTimeoutStop;
   logic preambleQualityTimeoutStop, gpioAlmostEmpty, gpioAlmostFull, dutyCycleEnable;
   logic wakeupReloadOnSyncEnable, piggybackEnable, sniffTimerEnable, backoffSeedReload;
   logic listenBeforeTalkEnable, persistentAccessEnable, automaticFilterEnable;
   int miscompares = 0;
   int checkCount = 0;
   row_s rows [8] = '{'{8'h00, 6'h00, 36'h0}, '{8'h3D, 6'h08, 36'h7}, '{8'h46, 6'h10, 36'h8005},
      '{8'h7B, 6'h10, 36'h1021}, '{8'h8C, 6'h18, 36'h864CBF}, '{8'hB2, 6'h20, 36'h04C011BB7},
      '{8'hCF, 6'h00, 36'h0}, '{8'hE0, 6'h00, 36'h0}};
   logic [7:0] defs [11] = '{8'h2C, 8'h00, 8'h14, 8'h88, 8'h88, 8'h88, 8'h88, 8'h01, 8'h00,
      8'h40, 8'h00};
   assign hready = hreadyout;
   packet_protocol_config_regs dut (.*);
   // ==========================================================================
   // Bus and check tasks
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] v);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {idx, 2'h0};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, v};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      @(negedge clk);
   endtask : bus
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
      bus(idx, 1'b0, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask : rdchk
   // Waits two falling edges so the registered pass flag has followed the new input.
   task automatic sq(input logic [7:0] q, input logic [2:0] ind, input logic e);
      bus(IDX_QUALITY, 1'b1, q);
      @(posedge clk);
      syncQualityIndicator <= ind;
      repeat (2) @(negedge clk);
      `CHK(syncQualityPass, e)
   endtask : sq
   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // ==========================================================================
   // Clock, watchdog and sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      {hsel, hwrite, seqReloadRequest, seqAdvance} = 4'h0;
      {txAlmostEmpty, txAlmostFull, rxAlmostEmpty, rxAlmostFull} = 4'h0;
      htrans = 2'h0;
      haddr = '0;
      hsize = 3'h2;
      hwdata = 32'h0;
      syncQualityIndicator = 3'h0;
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) rdchk(8'(IDX_PKT_CTRL + i), defs[i]);
      `CHK(packetLength, 16'h0014)
      for (int i = 0; i < 8; i++) begin
         bus(IDX_PKT_CTRL, 1'b1, rows[i].v);
         `CHK(crcWidth, rows[i].w)
         `CHK(crcPolynomial, rows[i].p)
         `CHK(crcEnable, rows[i].w != 6'h00)
         `CHK({whiteningEnable, transmitOriginSelect}, rows[i].v[4:2])
         `CHK({txUseSecondarySync, errorCorrectionEnable}, rows[i].v[1:0])
         `CHK(rxDualSyncDetect, rows[i].v[1])
         rdchk(IDX_PKT_CTRL, rows[i].v);
      end
      for (int i = 0; i < 11; i++) bus(8'(IDX_PKT_CTRL + i), 1'b1, 8'(8'h5A + 8'h13 * i));
      for (int i = 0; i < 11; i++) rdchk(8'(IDX_PKT_CTRL + i), 8'(8'h5A + 8'h13 * i));
      `CHK(packetLength, 16'h6D80)
      `CHK(syncWord, 32'h93A6B9CC)
      `CHK({syncQualityThreshold, preambleQualityThreshold, syncQualityCheckEnable}, 8'hDF)
      `CHK(postambleLengthField, 8'hF2)
      `CHK({csTimeoutStop, syncQualityTimeoutStop, preambleQualityTimeoutStop}, 3'h0)
      `CHK(wakeupTimerMultiplier, 2'h1)
      bus(IDX_PROTO_TIMEOUT, 1'b1, 8'hE2);
      `CHK({csTimeoutStop, syncQualityTimeoutStop, preambleQualityTimeoutStop}, 3'h7)
      `CHK(wakeupTimerMultiplier, 2'h2)
      bus(IDX_PROTO_ACCESS, 1'b1, 8'hE7);
      `CHK({dutyCycleEnable, wakeupReloadOnSyncEnable, piggybackEnable}, 3'h7)
      `CHK({sniffTimerEnable, backoffSeedReload}, 2'h0)
      `CHK({listenBeforeTalkEnable, persistentAccessEnable}, 2'h3)
      `CHK(automaticFilterEnable, 1'b1)
      // An unmapped word must neither store nor disturb its neighbour.
      bus(8'h3B, 1'b1, 8'hFF);
      rdchk(8'h3B, 8'h00);
      rdchk(IDX_PROTO_ACCESS, 8'hE7);
      bus(IDX_PROTO_ACCESS, 1'b1, 8'h18);
      `CHK({backoffSeedReload, sniffTimerEnable}, 2'h3)
      @(negedge clk);
      `CHK(backoffSeedReload, 1'b0)
      // Reload and advance together: the reload must win, then three advances wrap.
      bus(IDX_PROTO_TIMEOUT, 1'b1, 8'h14);
      @(posedge clk);
      seqReloadRequest <= 1'b1;
      seqAdvance <= 1'b1;
      @(posedge clk);
      seqReloadRequest <= 1'b0;
      repeat (3) @(posedge clk);
      seqAdvance <= 1'b0;
      @(negedge clk);
      `CHK(txSequenceNumber, 2'h1)
      bus(IDX_SEQ_CMD, 1'b1, 8'h01);
      rdchk(IDX_SEQ_CMD, 8'h02);
      @(posedge clk);
      txAlmostEmpty <= 1'b1;
      rxAlmostFull <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK({gpioAlmostEmpty, gpioAlmostFull}, 2'h2)
      bus(IDX_PROTO_TIMEOUT, 1'b1, 8'h10);
      @(negedge clk);
      `CHK({gpioAlmostEmpty, gpioAlmostFull}, 2'h1)
      sq(8'h81, 3'h3, 1'b0);
      sq(8'h81, 3'h4, 1'b1);
      sq(8'h80, 3'h0, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(IDX_PROTO_TIMEOUT, 8'h40);
      `CHK(txSequenceNumber, 2'h0)
      results();
   end
endmodule : tb
